// *** scu_card.sv ***
// smart card model on the open-drain io line
`timescale 1ns/10ps
module scu_card #(parameter int E = 4)
(
  input wire logic clock,
  input wire logic line,
  output logic card_low
);
  logic nack_en = 1'b0; // answer device chars with a nack
  logic busy = 1'b0; // card is sending
  logic [9:0] got = '0; // last device character seen on the line
  initial card_low = 1'b0;
  // one character, lsb first; release lets the pull-up win
  task automatic send(input logic [7:0] b, input logic par, input logic stp);
    logic [11:0] f;
    f = {1'b1, stp, par, b, 1'b0};
    busy = 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      card_low <= ~f[i];
      repeat (E) @(posedge clock);
    end
    busy = 1'b0;
  endtask
  // watch a device char at mid etu, then nack for two etus from the middle of its first guard etu
  always @(negedge line)
  begin
    if (!busy)
    begin
      repeat (E / 2) @(posedge clock);
      for (int i = 0; i < 10; i++)
      begin
        got[i] = line;
        repeat (E) @(posedge clock);
      end
      if (nack_en)
      begin
        card_low <= 1'b1;
        repeat (E * 2) @(posedge clock);
        card_low <= 1'b0;
      end
    end
  end
endmodule

// *** scu_etu.sv ***
// etu divider: one-cycle mid and end pulses per elementary time unit
`timescale 1ns/10ps
module scu_etu
  import scu_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] div,
  scu_etu_if.gen etu
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cnt; // clocks into the etu
    logic half; // mid pulse
    logic tick; // end pulse
  } scu_etu_s;
  scu_etu_s s_r;
  scu_etu_s s_nxt;

  assign etu.half = s_r.half;
  assign etu.tick = s_r.tick;

  // next state: restart wins, else count and wrap
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.half = 1'b0;
    s_nxt.tick = 1'b0;
    if (etu.restart)
    begin
      s_nxt.cnt = '0;
    end
    else if (s_r.cnt >= div - 16'h0001)
    begin
      s_nxt.cnt = '0;
      s_nxt.tick = 1'b1;
    end
    else
    begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
      s_nxt.half = (s_r.cnt == {1'b0, div[15:1]});
    end
  end

  // state register
  always_ff @(posedge clock)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule

// *** scu_etu_if.sv ***
// etu timing handshake between the uart core and its etu dividers
`timescale 1ns/10ps
interface scu_etu_if;
  logic restart; // align the etu grid to this cycle
  logic half; // pulse in the middle of an etu
  logic tick; // pulse at the end of an etu
  modport gen (input restart, output half, output tick);
  modport user (output restart, input half, input tick);
endinterface

// *** scu_irq.sv ***
// interrupt combiner: level request while any enabled flag stands
`timescale 1ns/10ps
module scu_irq
  import scu_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] flags,
  input wire logic [7:0] enables,
  output logic irq
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic irq; // registered request
  } scu_irq_s;
  scu_irq_s s_r;
  scu_irq_s s_nxt;

  assign irq = s_r.irq;

  // gate each flag by its enable
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.irq = |(flags & enables);
  end

  // state register
  always_ff @(posedge clock)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule

// *** scu_pkg.sv ***
// shared constants, register map and state types of the smart-card uart
package scu_pkg;
  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL_TWO = 8'h00; // enables and queue strobes
  localparam logic [7:0] OFS_CONTROL_THREE = 8'h04; // pin direction, tx inversion
  localparam logic [7:0] OFS_STATUS_ONE = 8'h08; // transfer and error flags
  localparam logic [7:0] OFS_STATUS_TWO = 8'h0c; // bit order, rx inversion
  localparam logic [7:0] OFS_DATA = 8'h10; // tx write / rx read
  localparam logic [7:0] OFS_SC_CONTROL = 8'h14; // protocol, detect, nack limit
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18; // smartcard_irq_status, write one to clear
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1c; // per-flag interrupt enables
  localparam logic [7:0] OFS_ETU_DIV = 8'h20; // clocks per etu
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_TX_ENABLE = 0; // control_two
  localparam int BIT_RX_ON = 1;
  localparam int BIT_QUEUE_PREAMBLE = 2;
  localparam int BIT_QUEUE_BREAK = 3;
  localparam int BIT_TX_PIN_DIRECTION = 0; // control_three
  localparam int BIT_TX_POLARITY_INVERT = 1;
  localparam int BIT_TX_BUFFER_EMPTY = 0; // status_one holds bits 0-5, irq enable layout all 8
  localparam int BIT_TX_COMPLETE = 1;
  localparam int BIT_RX_FULL = 2;
  localparam int BIT_FRAMING_ERROR = 3;
  localparam int BIT_NOISE = 4;
  localparam int BIT_PARITY_ERROR = 5;
  localparam int BIT_NACK_THRESHOLD = 6;
  localparam int BIT_INIT_DONE = 7;
  localparam int BIT_MSB_FIRST_ORDER = 0; // status_two
  localparam int BIT_RX_POLARITY_INVERT = 1;
  localparam int BIT_T1_MODE = 0; // sc_control
  localparam int BIT_INIT_DETECT = 1;
  localparam int POS_NACK_LIMIT = 2; // 3-bit field
  localparam int IRQ_BIT_NACK = 0; // smartcard_irq_status
  localparam int IRQ_BIT_INIT = 1;
  // ------------------------------------------------------------
  // reset values, character codes and etu counts
  // ------------------------------------------------------------
  localparam logic [15:0] RST_ETU_DIV = 16'h0174; // 372 clocks per etu
  localparam logic [7:0] TS_DIRECT = 8'h3b; // raw initial char, direct
  localparam logic [7:0] TS_INVERSE = 8'h03; // raw initial char, inverse
  localparam logic [3:0] DATA_ETU = 4'ha; // start, 8 data, parity
  localparam logic [3:0] CHAR_T0_ETU = 4'hc; // t=0 character with guard
  localparam logic [3:0] CHAR_T1_ETU = 4'hb; // t=1 character, one stop bit
  localparam logic [3:0] NACK_EXTRA_ETU = 4'h1; // extra guard after a nack
  // ------------------------------------------------------------
  // state types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {SCU_TX_IDLE, SCU_TX_BITS, SCU_TX_GUARD} scu_tx_e;
  typedef enum logic [1:0] {SCU_RX_IDLE, SCU_RX_BITS} scu_rx_e;
  typedef enum logic [1:0] {SCU_K_DATA, SCU_K_PRE, SCU_K_BRK} scu_kind_e;

  // bit order and polarity conversion, its own inverse
  function automatic logic [7:0] scu_conv(input logic [7:0] d, input logic msb, input logic inv);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = msb ? d[7 - i] : d[i];
    end
    return r ^ {8{inv}};
  endfunction
endpackage

// *** scu_uart.sv ***
// smart-card uart core: wishbone registers, t=0/t=1 transmit, receive, flags
`timescale 1ns/10ps
// Function
// - t=1 transmit frames with one stop
// - receiver takes one stop; t=0 senders use 12
// - transmit complete only after guard time
// - tx enable low clears nack counter
// - nack threshold flag cleared by writing one
// - pin direction bit drives the line
// - framing error pending discards received characters
// - framing clear also clears noise, parity
// - tx complete clears: status read, then write/queue
// - every tx complete clear needs its read
// - initial detect sets done on valid char
module scu_uart
  import scu_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  input wire logic card_io_in,
  output logic card_io_out,
  output logic card_io_oe
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic ack; // bus answer
    logic [31:0] rdat; // read data
    logic tx_enable, rx_on, tx_pin_direction, tx_polarity_invert;
    logic msb_first_order, rx_polarity_invert, t1_mode, init_detect;
    logic [2:0] nack_limit; // retries before flagging
    logic [15:0] etu_div; // clocks per etu
    logic [7:0] irq_en; // interrupt enables
    logic tx_buffer_empty, tx_complete_flag, tc_arm; // tc_arm: status seen
    logic rx_full, framing_error_flag, noise_flag, parity_error_flag, fe_arm;
    logic nack_threshold_flag, initial_detect_done;
    logic q_pre, q_brk; // queued idle / break characters
    logic [7:0] rxbuf, txbuf;
    logic [2:0] nack_cnt; // nacks for the current character
    scu_tx_e txs;
    scu_kind_e txk;
    logic [9:0] txfr, txsh; // frame copy for resend, shifter
    logic [3:0] txbit; // etu index within the character
    logic txnack; // nack seen in this character
    scu_rx_e rxs;
    logic [8:0] rxsh; // data and parity bits
    logic [3:0] rxbit; // sample index
    logic io_oe;
  } scu_state_s;
  scu_state_s s_r;
  scu_state_s n;

  scu_etu_if tx_etu ();
  scu_etu_if rx_etu ();
  logic tx_rs; // restart the tx etu grid
  logic rx_rs; // restart the rx etu grid
  logic [7:0] flags; // status flags in enable layout
  logic [7:0] rx_logical; // received byte after order and polarity
  logic [3:0] tx_len; // etus in the current character
  logic [9:0] tx_frame; // line bits of the buffered byte
  logic bus_rd, bus_wr; // accepted access, sampled at ack rise

  // ------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------
  scu_etu u_tx_etu (.clock(clock), .rst(rst), .div(s_r.etu_div), .etu(tx_etu.gen));
  scu_etu u_rx_etu (.clock(clock), .rst(rst), .div(s_r.etu_div), .etu(rx_etu.gen));
  scu_irq u_irq (.clock(clock), .rst(rst), .flags(flags), .enables(s_r.irq_en), .irq(irq));

  assign tx_etu.restart = tx_rs;
  assign rx_etu.restart = rx_rs;
  assign flags = {s_r.initial_detect_done, s_r.nack_threshold_flag, s_r.parity_error_flag,
                  s_r.noise_flag, s_r.framing_error_flag, s_r.rx_full, s_r.tx_complete_flag,
                  s_r.tx_buffer_empty};
  assign rx_logical = scu_conv(s_r.rxsh[7:0], s_r.msb_first_order, s_r.rx_polarity_invert);
  assign tx_frame = {(^s_r.txbuf) ^ s_r.tx_polarity_invert,
                     scu_conv(s_r.txbuf, s_r.msb_first_order, s_r.tx_polarity_invert), 1'b0};
  assign tx_len = (s_r.t1_mode ? CHAR_T1_ETU : CHAR_T0_ETU) + (s_r.txnack ? NACK_EXTRA_ETU : 4'h0);
  assign bus_rd = wb_cyc_i & wb_stb_i & ~s_r.ack & ~wb_we_i;
  assign bus_wr = wb_cyc_i & wb_stb_i & ~s_r.ack & wb_we_i & wb_sel_i[0];
  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.rdat;
  assign card_io_out = 1'b0; // open drain: only low is driven
  assign card_io_oe = s_r.io_oe;

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb
  begin
    n = s_r;
    tx_rs = 1'b0;
    rx_rs = 1'b0;
    n.ack = wb_cyc_i & wb_stb_i & ~s_r.ack;
    // register reads
    if (bus_rd)
    begin
      n.rdat = '0;
      case (wb_adr_i)
        OFS_CONTROL_TWO:
        begin
          n.rdat[BIT_TX_ENABLE] = s_r.tx_enable;
          n.rdat[BIT_RX_ON] = s_r.rx_on;
        end
        OFS_CONTROL_THREE:
        begin
          n.rdat[BIT_TX_PIN_DIRECTION] = s_r.tx_pin_direction;
          n.rdat[BIT_TX_POLARITY_INVERT] = s_r.tx_polarity_invert;
        end
        OFS_STATUS_ONE:
        begin
          n.rdat[5:0] = flags[5:0];
          if (s_r.tx_complete_flag)
            n.tc_arm = 1'b1;
          if (s_r.framing_error_flag)
            n.fe_arm = 1'b1;
        end
        OFS_STATUS_TWO:
        begin
          n.rdat[BIT_MSB_FIRST_ORDER] = s_r.msb_first_order;
          n.rdat[BIT_RX_POLARITY_INVERT] = s_r.rx_polarity_invert;
        end
        OFS_DATA:
        begin
          n.rdat[7:0] = s_r.rxbuf;
          n.rx_full = 1'b0;
          if (s_r.fe_arm)
          begin
            n.framing_error_flag = 1'b0;
            n.noise_flag = 1'b0;
            n.parity_error_flag = 1'b0;
            n.fe_arm = 1'b0;
          end
        end
        OFS_SC_CONTROL:
          n.rdat[4:0] = {s_r.nack_limit, s_r.init_detect, s_r.t1_mode};
        OFS_IRQ_STATUS:
          n.rdat[1:0] = {s_r.initial_detect_done, s_r.nack_threshold_flag};
        OFS_IRQ_ENABLE:
          n.rdat[7:0] = s_r.irq_en;
        OFS_ETU_DIV:
          n.rdat[15:0] = s_r.etu_div;
        default:
          n.rdat = '0; // unmapped reads zero
      endcase
    end
    // register writes
    if (bus_wr)
    begin
      case (wb_adr_i)
        OFS_CONTROL_TWO:
        begin
          n.tx_enable = wb_dat_i[BIT_TX_ENABLE];
          n.rx_on = wb_dat_i[BIT_RX_ON];
          if (wb_dat_i[BIT_QUEUE_PREAMBLE])
            n.q_pre = 1'b1;
          if (wb_dat_i[BIT_QUEUE_BREAK])
            n.q_brk = 1'b1;
          if ((wb_dat_i[BIT_QUEUE_PREAMBLE] | wb_dat_i[BIT_QUEUE_BREAK]) & s_r.tc_arm)
          begin
            n.tx_complete_flag = 1'b0;
            n.tc_arm = 1'b0;
          end
        end
        OFS_CONTROL_THREE:
        begin
          n.tx_pin_direction = wb_dat_i[BIT_TX_PIN_DIRECTION];
          n.tx_polarity_invert = wb_dat_i[BIT_TX_POLARITY_INVERT];
        end
        OFS_STATUS_TWO:
        begin
          n.msb_first_order = wb_dat_i[BIT_MSB_FIRST_ORDER];
          n.rx_polarity_invert = wb_dat_i[BIT_RX_POLARITY_INVERT];
        end
        OFS_DATA:
        begin
          n.txbuf = wb_dat_i[7:0];
          n.tx_buffer_empty = 1'b0;
          if (s_r.tc_arm)
          begin
            n.tx_complete_flag = 1'b0;
            n.tc_arm = 1'b0;
          end
        end
        OFS_SC_CONTROL:
        begin
          n.t1_mode = wb_dat_i[BIT_T1_MODE];
          n.init_detect = wb_dat_i[BIT_INIT_DETECT];
          n.nack_limit = wb_dat_i[POS_NACK_LIMIT +: 3];
        end
        OFS_IRQ_STATUS:
        begin
          if (wb_dat_i[IRQ_BIT_NACK])
            n.nack_threshold_flag = 1'b0;
          if (wb_dat_i[IRQ_BIT_INIT])
            n.initial_detect_done = 1'b0;
        end
        OFS_IRQ_ENABLE:
          n.irq_en = wb_dat_i[7:0];
        OFS_ETU_DIV:
        begin
          n.etu_div[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1])
            n.etu_div[15:8] = wb_dat_i[15:8];
        end
        default:
          n.ack = n.ack; // unmapped writes ignored
      endcase
    end
    // transmitter
    case (s_r.txs)
      SCU_TX_IDLE:
      begin
        if (s_r.tx_enable & (s_r.q_brk | s_r.q_pre | ~s_r.tx_buffer_empty))
        begin
          if (s_r.q_brk)
          begin
            n.txfr = '0;
            n.txk = SCU_K_BRK;
            n.q_brk = 1'b0;
          end
          else if (s_r.q_pre)
          begin
            n.txfr = '1;
            n.txk = SCU_K_PRE;
            n.q_pre = 1'b0;
          end
          else
          begin
            n.txfr = tx_frame;
            n.txk = SCU_K_DATA;
            n.tx_buffer_empty = 1'b1;
          end
          n.txsh = n.txfr;
          n.txs = SCU_TX_BITS;
          n.txbit = '0;
          n.txnack = 1'b0;
          tx_rs = 1'b1;
        end
      end
      SCU_TX_BITS:
      begin
        if (tx_etu.tick)
        begin
          n.txsh = {1'b1, s_r.txsh[9:1]};
          n.txbit = s_r.txbit + 4'h1;
          if (s_r.txbit == DATA_ETU - 4'h1)
            n.txs = SCU_TX_GUARD;
        end
      end
      SCU_TX_GUARD:
      begin
        // t=0 data: the card pulls the line low in the first guard etu
        if (tx_etu.half & (s_r.txbit == DATA_ETU) & (s_r.txk == SCU_K_DATA) & ~s_r.t1_mode & ~card_io_in)
          n.txnack = 1'b1;
        if (tx_etu.tick)
        begin
          n.txbit = s_r.txbit + 4'h1;
          if (s_r.txbit == tx_len - 4'h1)
          begin
            n.txs = SCU_TX_IDLE;
            if (s_r.txnack & (s_r.nack_cnt != s_r.nack_limit))
            begin
              n.nack_cnt = s_r.nack_cnt + 3'h1; // resend the same character
              n.txsh = s_r.txfr;
              n.txbit = '0;
              n.txnack = 1'b0;
              n.txs = SCU_TX_BITS;
              tx_rs = 1'b1;
            end
            else
            begin
              if (s_r.txnack)
                n.nack_threshold_flag = 1'b1; // give up on the character
              n.nack_cnt = '0;
              if (n.tx_buffer_empty & ~n.q_pre & ~n.q_brk)
                n.tx_complete_flag = 1'b1;
            end
          end
        end
      end
      default:
        n.txs = SCU_TX_IDLE;
    endcase
    if (!s_r.tx_enable)
      n.nack_cnt = '0;
    n.io_oe = n.tx_pin_direction & (n.txs == SCU_TX_BITS) & ~n.txsh[0];
    // receiver, held off while the device owns the line
    case (s_r.rxs)
      SCU_RX_IDLE:
      begin
        if (s_r.rx_on & (s_r.txs == SCU_TX_IDLE) & (n.txs == SCU_TX_IDLE) & ~card_io_in)
        begin
          n.rxs = SCU_RX_BITS;
          n.rxbit = '0;
          rx_rs = 1'b1;
        end
      end
      SCU_RX_BITS:
      begin
        if (rx_etu.half)
        begin
          n.rxbit = s_r.rxbit + 4'h1;
          if (s_r.rxbit == 4'h0)
          begin
            if (card_io_in)
            begin
              n.rxs = SCU_RX_IDLE; // false start
              if (~s_r.framing_error_flag & ~s_r.init_detect)
                n.noise_flag = 1'b1;
            end
          end
          else if (s_r.rxbit != DATA_ETU)
            n.rxsh = {card_io_in, s_r.rxsh[8:1]};
          else
          begin
            // stop sample: one stop bit suffices, so 11 etu frames are taken
            n.rxs = SCU_RX_IDLE;
            if (s_r.init_detect)
            begin
              if ((s_r.rxsh[7:0] == TS_DIRECT) | (s_r.rxsh[7:0] == TS_INVERSE))
              begin
                n.initial_detect_done = 1'b1;
                n.init_detect = 1'b0;
              end
            end
            else if (!s_r.framing_error_flag)
            begin
              if (!card_io_in)
                n.framing_error_flag = 1'b1;
              else
              begin
                if ((^rx_logical) != (s_r.rxsh[8] ^ s_r.rx_polarity_invert))
                  n.parity_error_flag = 1'b1;
                if (!n.rx_full)
                begin
                  n.rxbuf = rx_logical;
                  n.rx_full = 1'b1;
                end
              end
            end
            // else: character discarded while framing error pends
          end
        end
      end
      default:
        n.rxs = SCU_RX_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.etu_div <= RST_ETU_DIV;
      s_r.tx_buffer_empty <= 1'b1;
      s_r.tx_complete_flag <= 1'b1;
      s_r.txs <= SCU_TX_IDLE;
      s_r.rxs <= SCU_RX_IDLE;
    end
    else
      s_r <= n;
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  AST_TC_NEEDS_READ: assert property (s_r.tx_complete_flag & ~s_r.tc_arm & bus_wr & (wb_adr_i == OFS_DATA)
    |=> s_r.tx_complete_flag) else $error("tx complete cleared without status read");
  AST_TC_CLEAR: assert property (s_r.tc_arm & bus_wr & (wb_adr_i == OFS_DATA) & (s_r.txs == SCU_TX_IDLE)
    |=> ~s_r.tx_complete_flag) else $error("tx complete not cleared by data write");
  AST_TC_GUARD: assert property ($rose(s_r.tx_complete_flag) |-> $past(s_r.txs) == SCU_TX_GUARD)
    else $error("tx complete rose outside guard end");
  AST_NACK_RESET: assert property (~s_r.tx_enable |=> s_r.nack_cnt == 3'h0)
    else $error("nack counter kept with tx disabled");
  AST_NACK_W1C: assert property (bus_wr & (wb_adr_i == OFS_IRQ_STATUS) & wb_dat_i[IRQ_BIT_NACK]
    & (s_r.txs != SCU_TX_GUARD) |=> ~s_r.nack_threshold_flag) else $error("nack flag not cleared");
  AST_OE_DIR: assert property (card_io_oe |-> s_r.tx_pin_direction & (s_r.txs == SCU_TX_BITS))
    else $error("pin driven without direction");
  AST_FE_DISCARD: assert property (s_r.framing_error_flag & ~bus_rd ##1 s_r.framing_error_flag
    |-> $stable(s_r.rxbuf)) else $error("character stored during framing error");
  AST_FE_QUIET: assert property (s_r.framing_error_flag |=> ~$rose(s_r.noise_flag) & ~$rose(s_r.parity_error_flag))
    else $error("noise or parity raised while framing error");
  AST_FE_CLEAR: assert property (s_r.fe_arm & bus_rd & (wb_adr_i == OFS_DATA)
    |=> ~s_r.framing_error_flag & ~s_r.noise_flag & ~s_r.parity_error_flag) else $error("error flags kept");
  AST_IRQ: assert property (##1 1'b1 |-> irq == |($past(flags) & $past(s_r.irq_en)))
    else $error("interrupt does not follow enabled flags");
  AST_INIT: assert property ($rose(s_r.initial_detect_done) |-> $past(s_r.init_detect))
    else $error("init done without detection");
  COV_NACK_RETRY: cover property (s_r.txnack ##[1:600] (s_r.txs == SCU_TX_BITS));
  COV_INIT_DONE: cover property ($rose(s_r.initial_detect_done));
  COV_FRAMING: cover property ($rose(s_r.framing_error_flag));
  COV_TC_CLEAR: cover property (s_r.tx_complete_flag ##1 ~s_r.tx_complete_flag);
endmodule

// *** test_smartcard_uart_iso7816.sv ***
// self-checking bench of the smart-card uart
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
  $display("wrong value %0t got %h exp %h", $time, a, e); end end
module test_smartcard_uart_iso7816 import scu_pkg::*;;
  logic clock = 1'b0; // 25 ns clock
  logic rst = 1'b1; // synchronous reset
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // bus controls
  logic [7:0] adr = '0, b, r; // address, test bytes
  logic [31:0] dat = '0, rdat; // bus data
  logic ack, irq, io_out, io_oe, card_low, seen_oe = 1'b0;
  int n, fail_count = 0, compares = 0;
  localparam int ETU = 16; // clocks per etu in this run
  logic [63:0] notes[$]; // mask and expected of each read
  wire line = ~(io_oe | card_low); // open drain with pull-up
  always #12.5 clock = ~clock;
  scu_uart scu_uart_inst (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq),
    .card_io_in(line), .card_io_out(io_out), .card_io_oe(io_oe));
  scu_card #(.E(ETU)) scu_card_inst (.clock(clock), .line(line), .card_low(card_low));
  // one classic wishbone cycle, held until ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do @(posedge clock); while (ack !== 1'b1);
    {cyc, stb} <= 2'b00;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  // read: note expected value first
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back({m, e});
    bus(1'b0, a, '0);
  endtask
  // bounded wait for the interrupt, cycles counted
  task automatic wirq(output int c);
    for (c = 0; c < 3000 && irq !== 1'b1; c++) @(posedge clock);
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // read data checker, oldest note first
  always @(posedge clock)
    if (ack === 1'b1 && !we && notes.size() > 0)
    begin
      `CHK(rdat & notes[0][63:32], notes[0][31:0])
      void'(notes.pop_front());
    end
  always @(posedge clock) if (io_oe === 1'b1) seen_oe <= 1'b1;
  // main sequence
  initial
  begin
    void'($urandom(10560));
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rd(OFS_STATUS_ONE, 32'h3, '1);
    rd(OFS_ETU_DIV, 32'h174, '1);
    rd(8'h24, '0, '1);
    wr(OFS_ETU_DIV, ETU);
    $display("test registers done");
    wr(OFS_CONTROL_THREE, 32'h1);
    wr(OFS_CONTROL_TWO, 32'h1);
    wr(OFS_CONTROL_TWO, 32'h3);
    wr(OFS_IRQ_ENABLE, 32'h2);
    `CHK(irq, 1'b1)
    for (int k = 0; k < 2; k++)
    begin
      wr(OFS_SC_CONTROL, k);
      rd(OFS_STATUS_ONE, 32'h2, 32'h2);
      b = 8'($urandom);
      wr(OFS_DATA, {24'h0, b});
      `CHK(irq, 1'b0)
      wirq(n);
      `CHK(n / ETU, k ? 11 : 12)
      `CHK(scu_card_inst.got, {^b, b, 1'b0})
    end
    `CHK(seen_oe, 1'b1)
    `CHK(io_out, 1'b0)
    rd(OFS_STATUS_ONE, 32'h2, 32'h2);
    wr(OFS_CONTROL_TWO, 32'hf);
    `CHK(irq, 1'b0)
    wirq(n);
    wr(OFS_DATA, {24'h0, b});
    `CHK(irq, 1'b1)
    repeat (14 * ETU) @(posedge clock);
    $display("test transmit done");
    wr(OFS_SC_CONTROL, 32'h4); // t=0, one resend before giving up
    scu_card_inst.nack_en = 1'b1;
    rd(OFS_STATUS_ONE, 32'h2, 32'h2);
    wr(OFS_DATA, {24'h0, b});
    wirq(n);
    `CHK(n / ETU, 26)
    rd(OFS_IRQ_STATUS, 32'h1, 32'h1);
    wr(OFS_IRQ_STATUS, 32'h1);
    rd(OFS_IRQ_STATUS, 32'h0, 32'h1);
    scu_card_inst.nack_en = 1'b0;
    $display("test nack done");
    wr(OFS_CONTROL_TWO, 32'h2);
    wr(OFS_SC_CONTROL, 32'h2);
    scu_card_inst.send(8'ha5, 1'b0, 1'b1);
    scu_card_inst.send(TS_DIRECT, 1'b1, 1'b1);
    rd(OFS_IRQ_STATUS, 32'h2, 32'h2);
    rd(OFS_STATUS_ONE, 32'h0, 32'h3c);
    b = 8'($urandom);
    scu_card_inst.send(b, ^b, 1'b1);
    rd(OFS_STATUS_ONE, 32'h4, 32'h3c);
    rd(OFS_DATA, {24'h0, b}, 32'hff);
    wr(OFS_STATUS_TWO, 32'h3);
    wr(OFS_CONTROL_THREE, 32'h3);
    b = 8'($urandom);
    r = {<<{b}};
    scu_card_inst.send(~r, ~^b, 1'b1);
    rd(OFS_DATA, {24'h0, b}, 32'hff);
    wr(OFS_STATUS_TWO, '0);
    scu_card_inst.send(~b, ^b, 1'b0);
    repeat (60) @(posedge clock);
    scu_card_inst.send(~b, ~^b, 1'b1);
    rd(OFS_STATUS_ONE, 32'h8, 32'h3c);
    rd(OFS_DATA, {24'h0, b}, 32'hff);
    rd(OFS_STATUS_ONE, 32'h0, 32'h38);
    $display("test receive done");
    report_and_stop();
  end
  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clock);
    fail_count++;
    report_and_stop();
  end
endmodule
